// ---- core/duhm_pkg.sv ----
// package: register map, field positions and state types of the dual serial pin logic
package duhm_pkg;
  // channels served by one host bus
  localparam int NCH = 2;

  // register offsets on the three address inputs
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IRQ_EN = 3'h1;
  localparam logic [2:0] REG_IIR = 3'h2;
  localparam logic [2:0] REG_LCR = 3'h3;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_LSR = 3'h5;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam logic [2:0] REG_SCR = 3'h7;

  // field positions
  localparam int LCR_DIV_ACCESS = 7;
  localparam int IRQ_EN_MSI = 3;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int FCR_EN = 0;
  localparam int FCR_DMA = 3;

  // multi-function pin selections
  localparam logic [1:0] PINSEL_OUT2 = 2'h0;
  localparam logic [1:0] PINSEL_BAUD = 2'h1;
  localparam logic [1:0] PINSEL_RX_DMA = 2'h2;

  // fixed read values: no data path, holding and shift registers always empty
  localparam logic [7:0] LSR_IDLE = 8'h60;
  localparam logic [7:0] RBR_EMPTY = 8'h00;

  // modem inputs of one channel, all active low
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } duhm_modem_t;

  // pins driven by one channel
  typedef struct packed {
    logic dtr_n;
    logic rts_n;
    logic multi_function_pin;
    logic irq;
    logic serial_out;
    logic tx_dma_request_n;
  } duhm_pins_t;

  // per-channel state
  typedef struct packed {
    logic [7:0] lcr;
    logic [3:0] irq_en;
    logic [4:0] mcr;
    logic [7:0] scr;
    logic [2:0] afr;
    logic fen;
    logic fdma;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] prev;
    logic [3:0] delta;
    logic [15:0] cnt;
  } duhm_chan_t;

  // whole state of the block
  typedef struct packed {
    duhm_chan_t [NCH-1:0] ch;
    duhm_pins_t [NCH-1:0] pins;
    logic [NCH-1:0] msr_rd;
    logic rd_q;
    logic oe;
    logic [7:0] dout;
  } duhm_top_t;

  // reset values; synchronisers start at the idle (high) input level
  localparam duhm_pins_t PINS_RST =
    '{dtr_n: 1'h1, rts_n: 1'h1, multi_function_pin: 1'h1, irq: 1'h0, serial_out: 1'h1,
      tx_dma_request_n: 1'h0};
  localparam duhm_chan_t CH_RST = '{s1: 4'hF, s2: 4'hF, prev: 4'hF, default: '0};
endpackage

// ---- core/duhm_core.sv ----
// module: host bus, modem status and modem control pin logic of a dual serial controller
//
// Behaviour
// - channel select high addresses channel one, low addresses channel two.
// - registers are read or written only while chip select is low.
// - three address bits pick a register; divisor-access bit reveals divisors and alt reg.
// - modem status bit 4 reads the inverse of clear-to-send.
// - bit 0 flags any clear-to-send change since the last status read.
// - clear-to-send and carrier-detect are status only, never gate data.
// - bit 7 is inverse carrier-detect; bit 3 flags its changes.
// - bit 5 is inverse set-ready; bit 1 flags its changes.
// - bit 6 is inverse ring; bit 2 set only on ring input low-to-high.
// - with status interrupt enabled, any change flag raises the interrupt.
// - terminal-ready goes low when control bit 0 set; high on reset, loopback.
// - request-to-send goes low when control bit 1 set; high on reset, loopback.
// - channel interrupt goes high while any enabled source is pending.
// - interrupt falls when the source is serviced, and on master reset.
// - alt register bits 2:1 pick user output two, baud clock or rx dma.
// - user output two low when control bit 3 set; high on reset, loopback.
// - baud clock is input clock divided by the channel divisor, for divisors of two and up.
// - master reset clears control, scratch, fifo, alt, flag registers and pins; divisor latches and synchronisers keep their values.
// - master reset drives serial output to marking (one).
// - fifo control bit 3 picks dma type; only mode 0 outside fifo mode.
// - mode 0 signals single transfers, mode 1 requests until fifo full; here both modes hold the transmit request active at all times.
// - eight-bit data bus carries data, control and status, three-stated.
`timescale 1ns/10ps
module duhm_core (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic master_reset_in_i,
  // host bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic channel_select_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  // modem side, one entry per channel (index 0 is channel one)
  input duhm_pkg::duhm_modem_t [duhm_pkg::NCH-1:0] modem_n_i,
  output duhm_pkg::duhm_pins_t [duhm_pkg::NCH-1:0] chan_pins_o
);
  import duhm_pkg::*;

  duhm_top_t q;
  duhm_top_t next_q;
  logic acc_rd;
  logic acc_wr;
  logic sel;
  logic [NCH-1:0][3:0] eff_v;
  logic [NCH-1:0][7:0] msr_v;

  // bus strobes only count while the chip is selected
  assign acc_rd = !cs_n_i && !rd_n_i;
  assign acc_wr = !cs_n_i && !wr_n_i;
  // index 0 is channel one, picked by a high select level
  assign sel = ~channel_select_i;

  // next state of both channels and of the bus answer
  always_comb begin
    logic [15:0] div;
    logic [3:0] chg;
    logic hit;
    logic clr;
    logic div_access;
    logic loop;
    logic baud_n;
    logic out2_n;
    duhm_chan_t sc;
    div = 16'h0000;
    chg = 4'h0;
    hit = 1'h0;
    clr = 1'h0;
    div_access = 1'h0;
    loop = 1'h0;
    baud_n = 1'h1;
    out2_n = 1'h1;
    sc = q.ch[sel];
    next_q = q;
    eff_v = '0;
    msr_v = '0;
    for (int c = 0; c < NCH; c++) begin
      // two flops per modem input; only the second is looked at
      next_q.ch[c].s1 = modem_n_i[c];
      next_q.ch[c].s2 = q.ch[c].s1;
      // loopback feeds the status side from the control bits instead of the pins
      if (q.ch[c].mcr[MCR_LOOP]) begin
        eff_v[c] = ~{q.ch[c].mcr[MCR_OUT2], q.ch[c].mcr[MCR_OUT1],
                     q.ch[c].mcr[MCR_DTR], q.ch[c].mcr[MCR_RTS]};
      end else begin
        eff_v[c] = q.ch[c].s2;
      end
      next_q.ch[c].prev = eff_v[c];
      // change detect; ring only counts its trailing edge (input rising)
      chg[0] = eff_v[c][0] ^ q.ch[c].prev[0];
      chg[1] = eff_v[c][1] ^ q.ch[c].prev[1];
      chg[2] = eff_v[c][2] & ~q.ch[c].prev[2];
      chg[3] = eff_v[c][3] ^ q.ch[c].prev[3];
      // inputs only reach this status byte, nothing in the data path
      msr_v[c] = {~eff_v[c], q.ch[c].delta};
      hit = (c == int'(sel));
      // flags clear as the status read ends, so the host sees them first
      clr = q.rd_q && !acc_rd && q.msr_rd[c];
      next_q.msr_rd[c] = acc_rd && hit && (addr_i == REG_MSR);
      // a change landing on the clearing edge still sets its flag
      next_q.ch[c].delta = (clr ? 4'h0 : q.ch[c].delta) | chg;
      div_access = q.ch[c].lcr[LCR_DIV_ACCESS];
      // host writes, taken every cycle the strobe is low; reads win a collision
      if (acc_wr && hit && !acc_rd) begin
        unique case (addr_i)
          REG_DATA: begin
            if (div_access) begin
              next_q.ch[c].dll = host_data_bus_i;
            end
          end
          REG_IRQ_EN: begin
            if (div_access) begin
              next_q.ch[c].dlm = host_data_bus_i;
            end else begin
              next_q.ch[c].irq_en = host_data_bus_i[3:0];
            end
          end
          REG_IIR: begin
            if (div_access) begin
              next_q.ch[c].afr = host_data_bus_i[2:0];
            end else begin
              next_q.ch[c].fen = host_data_bus_i[FCR_EN];
              // dma type only sticks in fifo mode
              next_q.ch[c].fdma = host_data_bus_i[FCR_EN] & host_data_bus_i[FCR_DMA];
            end
          end
          REG_LCR: next_q.ch[c].lcr = host_data_bus_i;
          REG_MCR: next_q.ch[c].mcr = host_data_bus_i[4:0];
          REG_SCR: next_q.ch[c].scr = host_data_bus_i;
          REG_LSR, REG_MSR: ; // read-only offsets
        endcase
      end
      // baud divider; divisor zero stops it, divisor one cannot toggle
      div = {q.ch[c].dlm, q.ch[c].dll};
      if (div == 16'h0000) begin
        next_q.ch[c].cnt = 16'h0000;
      end else if (q.ch[c].cnt == 16'h0000) begin
        next_q.ch[c].cnt = div - 16'h0001;
      end else begin
        next_q.ch[c].cnt = q.ch[c].cnt - 16'h0001;
      end
      baud_n = (div == 16'h0000) || (next_q.ch[c].cnt >= (div >> 1));
      // modem control pins, parked inactive in loopback
      loop = next_q.ch[c].mcr[MCR_LOOP];
      next_q.pins[c].dtr_n = loop | ~next_q.ch[c].mcr[MCR_DTR];
      next_q.pins[c].rts_n = loop | ~next_q.ch[c].mcr[MCR_RTS];
      out2_n = loop | ~next_q.ch[c].mcr[MCR_OUT2];
      // receive dma ready stays inactive: there is no receive fifo here
      unique case (next_q.ch[c].afr[2:1])
        PINSEL_BAUD: next_q.pins[c].multi_function_pin = baud_n;
        PINSEL_RX_DMA: next_q.pins[c].multi_function_pin = 1'h1;
        default: next_q.pins[c].multi_function_pin = out2_n;
      endcase
      // modem status is the only live source; others never pend here
      next_q.pins[c].irq = next_q.ch[c].irq_en[IRQ_EN_MSI]
        & (|next_q.ch[c].delta);
      next_q.pins[c].serial_out = 1'h1;
      // holding register always empty, so both dma modes request at once
      next_q.pins[c].tx_dma_request_n = 1'h0;
      // master reset keeps divisors and the synchronisers
      if (master_reset_in_i) begin
        next_q.ch[c].lcr = 8'h00;
        next_q.ch[c].irq_en = 4'h0;
        next_q.ch[c].mcr = 5'h00;
        next_q.ch[c].scr = 8'h00;
        next_q.ch[c].afr = 3'h0;
        next_q.ch[c].fen = 1'h0;
        next_q.ch[c].fdma = 1'h0;
        next_q.ch[c].delta = 4'h0;
        next_q.ch[c].cnt = 16'h0000;
        next_q.pins[c] = PINS_RST;
      end
    end
    // read mux of the addressed channel
    div_access = sc.lcr[LCR_DIV_ACCESS];
    unique case (addr_i)
      REG_DATA: next_q.dout = div_access ? sc.dll : RBR_EMPTY;
      REG_IRQ_EN: next_q.dout = div_access ? sc.dlm : {4'h0, sc.irq_en};
      REG_IIR: begin
        if (div_access) begin
          next_q.dout = {5'h00, sc.afr};
        end else begin
          next_q.dout = {sc.fen, sc.fen, 5'h00, ~(sc.irq_en[IRQ_EN_MSI] & (|sc.delta))};
        end
      end
      REG_LCR: next_q.dout = sc.lcr;
      REG_MCR: next_q.dout = {3'h0, sc.mcr};
      REG_LSR: next_q.dout = LSR_IDLE;
      REG_MSR: next_q.dout = msr_v[sel];
      REG_SCR: next_q.dout = sc.scr;
    endcase
    // bus driven one cycle after the read strobe is seen, and only then
    next_q.rd_q = acc_rd;
    next_q.oe = acc_rd;
  end

  // state register; power-on reset also clears the divisors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ch <= {NCH{CH_RST}};
      q.pins <= {NCH{PINS_RST}};
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign host_data_bus_o = q.dout;
  assign host_data_bus_oe_o = q.oe;
  assign chan_pins_o = q.pins;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // status bit 4 follows the inverted clear-to-send of channel one
  property p_msr_cts;
    acc_rd && channel_select_i && addr_i == REG_MSR
      |=> host_data_bus_o[4] == ~$past(eff_v[0][0]);
  endproperty
  a_msr_cts: assert property (p_msr_cts)
    else $error("cts status bit not inverse of input");

  // status bit 7 of channel two is inverse carrier-detect
  property p_msr_dcd;
    acc_rd && !channel_select_i && addr_i == REG_MSR
      |=> host_data_bus_o[7] == ~$past(eff_v[1][3]);
  endproperty
  a_msr_dcd: assert property (p_msr_dcd)
    else $error("dcd status bit not inverse of input");

  // a clear-to-send edge sets its flag on the next cycle
  property p_clear_to_send_changed_set;
    (eff_v[0][0] != q.ch[0].prev[0]) && !master_reset_in_i |=> q.ch[0].delta[0];
  endproperty
  a_clear_to_send_changed_set: assert property (p_clear_to_send_changed_set)
    else $error("cts change not flagged");

  // set-ready change sets its flag within the next cycle
  property p_set_ready_changed_set;
    (eff_v[1][1] != q.ch[1].prev[1]) && !master_reset_in_i |=> q.ch[1].delta[1];
  endproperty
  a_set_ready_changed_set: assert property (p_set_ready_changed_set)
    else $error("dsr change not flagged");

  // ring flag only rises after the ring input went low to high
  property p_ring_trailing_edge_edge;
    $rose(q.ch[0].delta[2]) |-> $past(eff_v[0][2] && !q.ch[0].prev[2]);
  endproperty
  a_ring_trailing_edge_edge: assert property (p_ring_trailing_edge_edge)
    else $error("ring flag set without trailing edge");

  // pending enabled flag shows on the interrupt pin
  property p_irq_level;
    q.ch[0].irq_en[IRQ_EN_MSI] && q.ch[0].delta != 4'h0 |-> chan_pins_o[0].irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("enabled status change without interrupt");

  // end of a status read with quiet inputs clears flags and interrupt
  property p_read_clears;
    q.rd_q && !acc_rd && q.msr_rd[0] && eff_v[0] == q.ch[0].prev
      |=> q.ch[0].delta == 4'h0 ##0 !chan_pins_o[0].irq;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");

  // loopback parks the control pins inactive
  property p_loop_idle;
    q.ch[0].mcr[MCR_LOOP] |-> chan_pins_o[0].dtr_n && chan_pins_o[0].rts_n;
  endproperty
  a_loop_idle: assert property (p_loop_idle)
    else $error("control pin active in loopback");

  // data bus enable tracks the selected read strobe one cycle later
  property p_bus_enable;
    !master_reset_in_i |=> host_data_bus_oe_o == $past(acc_rd);
  endproperty
  a_bus_enable: assert property (p_bus_enable)
    else $error("data bus enable out of step with read");

  // master reset keeps divisors, clears control, marks the line
  property p_mr_keep;
    master_reset_in_i |=> q.ch[0].dll == $past(q.ch[0].dll)
      && q.ch[0].mcr == 5'h00 && chan_pins_o[0].serial_out;
  endproperty
  a_mr_keep: assert property (p_mr_keep)
    else $error("master reset lost divisor or left control set");

  // terminal-ready follows control bit 0 outside loopback
  property p_dtr_active;
    q.ch[0].mcr[MCR_DTR] && !q.ch[0].mcr[MCR_LOOP] |-> !chan_pins_o[0].dtr_n;
  endproperty
  a_dtr_active: assert property (p_dtr_active)
    else $error("terminal ready not driven low");

  // request-to-send follows control bit 1 outside loopback
  property p_rts_active;
    q.ch[0].mcr[MCR_RTS] && !q.ch[0].mcr[MCR_LOOP] |-> !chan_pins_o[0].rts_n;
  endproperty
  a_rts_active: assert property (p_rts_active)
    else $error("request to send not driven low");

  // user output two reaches the shared pin when it is the chosen function
  property p_out2_active;
    q.ch[0].afr[2:1] == PINSEL_OUT2 && q.ch[0].mcr[MCR_OUT2] && !q.ch[0].mcr[MCR_LOOP]
      |-> !chan_pins_o[0].multi_function_pin;
  endproperty
  a_out2_active: assert property (p_out2_active)
    else $error("user output two not on shared pin");

  // master reset parks channel two pins at their idle levels
  property p_mr_pins;
    master_reset_in_i |=> chan_pins_o[1].dtr_n && chan_pins_o[1].rts_n
      && chan_pins_o[1].multi_function_pin && !chan_pins_o[1].irq
      && chan_pins_o[1].serial_out;
  endproperty
  a_mr_pins: assert property (p_mr_pins)
    else $error("pin not idle after master reset");

  // channel one keeps its scratch byte when deselected or the chip is not selected
  property p_write_gated;
    (cs_n_i || !channel_select_i) && !master_reset_in_i
      |=> q.ch[0].scr == $past(q.ch[0].scr);
  endproperty
  a_write_gated: assert property (p_write_gated)
    else $error("register changed without being addressed");

  // a carrier-detect edge sets its flag on the next cycle
  property p_carrier_changed_set;
    (eff_v[0][3] != q.ch[0].prev[3]) && !master_reset_in_i |=> q.ch[0].delta[3];
  endproperty
  a_carrier_changed_set: assert property (p_carrier_changed_set)
    else $error("dcd change not flagged");

  // dma type only sticks with the fifos on; mode 0 otherwise
  property p_dma_mode0;
    !q.ch[0].fen |-> !q.ch[0].fdma;
  endproperty
  a_dma_mode0: assert property (p_dma_mode0)
    else $error("dma mode 1 without fifo mode");
endmodule // duhm_core

// ---- sim/duhm_modem_model.sv ----
// modem partner model: drives the active-low status lines of both channels
`timescale 1ns/10ps
module duhm_modem_model (
  // clock
  input wire logic clk_i,
  // status lines towards the device
  output duhm_pkg::duhm_modem_t [duhm_pkg::NCH-1:0] modem_n_o
);
  import duhm_pkg::*;

  // lines idle high, as an unplugged or quiet modem leaves them
  duhm_modem_t [NCH-1:0] lines = {NCH{4'hF}};

  assign modem_n_o = lines;

  // levels move on the falling edge, away from the device's sampling edge
  task automatic set_line(input int c, input logic [3:0] v);
    @(negedge clk_i);
    lines[c] = v;
  endtask
endmodule // duhm_modem_model

// ---- sim/duhm_core_tb_top.sv ----
// testbench: host bus, modem status and modem control pins of the dual serial logic
`timescale 1ns/10ps
module duhm_core_tb_top;
  import duhm_pkg::*;

  typedef struct packed {
    logic wr;
    logic ch;
    logic [2:0] a;
    logic [7:0] d;
  } duhm_row_t;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic master_rst = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic chs = 1'b1;
  logic [7:0] wdata = 8'h00;
  logic [7:0] dout;
  logic oe;
  logic [7:0] rd;
  logic prev;
  int rises;
  duhm_modem_t [NCH-1:0] modem_n;
  duhm_pins_t [NCH-1:0] pins;
  int error_cnt = 0;
  int check_count = 0;
  // plain register traffic: write rows store except the one to the read-only status offset, read rows give the byte beside them
  duhm_row_t rows [9] = '{
    '{1'b1, 1'b0, REG_SCR, 8'hA5}, '{1'b1, 1'b1, REG_SCR, 8'h5A},
    '{1'b0, 1'b0, REG_SCR, 8'hA5}, '{1'b0, 1'b1, REG_SCR, 8'h5A},
    '{1'b1, 1'b0, REG_LSR, 8'hFF}, '{1'b0, 1'b0, REG_LSR, LSR_IDLE},
    '{1'b0, 1'b0, REG_DATA, RBR_EMPTY}, '{1'b1, 1'b0, REG_LCR, 8'h03},
    '{1'b0, 1'b0, REG_LCR, 8'h03}};

  duhm_modem_model i_duhm_modem_model (.clk_i(clk_i), .modem_n_o(modem_n));

  duhm_core i_duhm_core (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .master_reset_in_i(master_rst),
    .cs_n_i(cs_n),
    .rd_n_i(rd_n),
    .wr_n_i(wr_n),
    .addr_i(addr),
    .channel_select_i(chs),
    .host_data_bus_i(wdata),
    .host_data_bus_o(dout),
    .host_data_bus_oe_o(oe),
    .modem_n_i(modem_n),
    .chan_pins_o(pins)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write cycle; channel index 0 is selected by a high select line
  task automatic bus_wr(input logic c, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    chs = ~c;
    wdata = d;
    @(negedge clk_i);
    cs_n = 1'b1;
    wr_n = 1'b1;
  endtask

  // one read cycle; the bus must float again once the strobe is gone
  task automatic bus_rd(input logic c, input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_i);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    chs = ~c;
    @(negedge clk_i);
    d = dout;
    chk1(oe, 1'b1);
    cs_n = 1'b1;
    rd_n = 1'b1;
    @(negedge clk_i);
    chk1(oe, 1'b0);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (rows[i].wr) begin
        bus_wr(rows[i].ch, rows[i].a, rows[i].d);
      end else begin
        bus_rd(rows[i].ch, rows[i].a, rd);
        chk8(rd, rows[i].d);
      end
    end
    $display("table done");
    // strobes without chip select must neither store nor drive
    @(negedge clk_i);
    addr = REG_SCR;
    chs = 1'b1;
    wdata = 8'h00;
    wr_n = 1'b0;
    @(negedge clk_i);
    wr_n = 1'b1;
    rd_n = 1'b0;
    @(negedge clk_i);
    @(negedge clk_i);
    chk1(oe, 1'b0);
    rd_n = 1'b1;
    bus_rd(1'b0, REG_SCR, rd);
    chk8(rd, 8'hA5);
    $display("select test done");
    // each status line low then high again, interrupt enabled on channel one
    bus_rd(1'b0, REG_MSR, rd);
    chk8(rd, 8'h00);
    bus_wr(1'b0, REG_IRQ_EN, 8'h08);
    for (int k = 0; k < 4; k++) begin
      i_duhm_modem_model.set_line(0, 4'hF ^ (4'h1 << k));
      repeat (6) @(negedge clk_i);
      chk1(pins[0].irq, k != 2);
      bus_rd(1'b0, REG_MSR, rd);
      chk8(rd, (8'h10 << k) | ((k != 2) ? (8'h01 << k) : 8'h00));
      repeat (2) @(negedge clk_i);
      chk1(pins[0].irq, 1'b0);
      i_duhm_modem_model.set_line(0, 4'hF);
      repeat (6) @(negedge clk_i);
      chk1(pins[0].irq, 1'b1);
      bus_rd(1'b0, REG_MSR, rd);
      chk8(rd, 8'h01 << k);
    end
    // channel two change stays on channel two, and its interrupt is disabled
    i_duhm_modem_model.set_line(1, 4'hE);
    repeat (6) @(negedge clk_i);
    chk1(pins[1].irq, 1'b0);
    bus_rd(1'b1, REG_MSR, rd);
    chk8(rd, 8'h11);
    bus_rd(1'b0, REG_MSR, rd);
    chk8(rd, 8'h00);
    $display("status test done");
    // modem control outputs, then loopback holds them inactive
    bus_wr(1'b0, REG_MCR, 8'h0B);
    repeat (2) @(negedge clk_i);
    chk1(pins[0].dtr_n, 1'b0);
    chk1(pins[0].rts_n, 1'b0);
    chk1(pins[0].multi_function_pin, 1'b0);
    bus_wr(1'b0, REG_MCR, 8'h1B);
    repeat (2) @(negedge clk_i);
    chk8({5'h00, pins[0].dtr_n, pins[0].rts_n, pins[0].multi_function_pin},
      8'h07);
    bus_wr(1'b0, REG_MCR, 8'h0B);
    $display("control test done");
    // divisor of four gives a four-clock baud period on the pin
    bus_wr(1'b0, REG_LCR, 8'h80);
    bus_wr(1'b0, REG_DATA, 8'h04);
    bus_wr(1'b0, REG_IRQ_EN, 8'h00);
    bus_wr(1'b0, REG_IIR, 8'h02);
    prev = pins[0].multi_function_pin;
    rises = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (pins[0].multi_function_pin === 1'b1 && prev === 1'b0) rises++;
      prev = pins[0].multi_function_pin;
    end
    chk8(8'(rises), 8'h0A);
    bus_wr(1'b0, REG_IIR, 8'h04);
    repeat (2) @(negedge clk_i);
    chk1(pins[0].multi_function_pin, 1'b1);
    bus_rd(1'b0, REG_DATA, rd);
    chk8(rd, 8'h04);
    $display("baud test done");
    // master reset: pins inactive, registers cleared, divisor kept
    @(negedge clk_i);
    master_rst = 1'b1;
    repeat (20) @(negedge clk_i);
    master_rst = 1'b0;
    chk8({3'h0, pins[0].dtr_n, pins[0].rts_n, pins[0].multi_function_pin, pins[0].irq,
      pins[0].serial_out}, 8'h1D);
    bus_rd(1'b0, REG_LCR, rd);
    chk8(rd, 8'h00);
    bus_wr(1'b0, REG_IIR, 8'h09);
    chk1(pins[0].tx_dma_request_n, 1'b0);
    // fifo mode now shows in the top two identification bits, nothing pending
    bus_rd(1'b0, REG_IIR, rd);
    chk8(rd, 8'hC1);
    bus_wr(1'b0, REG_LCR, 8'h80);
    bus_rd(1'b0, REG_DATA, rd);
    chk8(rd, 8'h04);
    $display("reset test done");
    conclude();
  end
endmodule // duhm_core_tb_top
